// ==== logic/agfd_regs.svh ====
/*
  constants for the address generator and format decoder: pc steps per length,
  register and vector numbers, reset pc and address-space limits.
  assumes inclusion by bare name from design files only.
*/
`ifndef AGFD_REGS_SVH
`define AGFD_REGS_SVH

`define AGFD_PC_STEP_HALF    32'h0000_0002
`define AGFD_PC_STEP_WORD    32'h0000_0004
`define AGFD_PROG_SPAN_MASK  32'h03ff_ffff
`define AGFD_CODE_LIN_LIMIT  32'h0100_0000
`define AGFD_IRAM_SIZE       32'h0000_f000
`define AGFD_EP_REG_NUM      5'h1e
`define AGFD_VEC_MAX         5'h1f
`define AGFD_RESET_PC        32'h0000_0000

`endif

// ==== logic/agfd_pkg.sv ====
/*
  types shared by the address generator and format decoder.
  assumes nothing of its surroundings.
*/
package agfd_pkg;

  typedef enum logic [3:0] {
    AGFD_FMT_I    = 4'h0,
    AGFD_FMT_II   = 4'h1,
    AGFD_FMT_III  = 4'h2,
    AGFD_FMT_IV   = 4'h3,
    AGFD_FMT_V    = 4'h4,
    AGFD_FMT_VI   = 4'h5,
    AGFD_FMT_VII  = 4'h6,
    AGFD_FMT_VIII = 4'h7,
    AGFD_FMT_IX   = 4'h8,
    AGFD_FMT_X    = 4'h9,
    AGFD_FMT_XI   = 4'ha,
    AGFD_FMT_XII  = 4'hb,
    AGFD_FMT_XIII = 4'hc
  } agfd_fmt_e;

  typedef enum logic [2:0] {
    AGFD_AM_NONE      = 3'h0,
    AGFD_AM_PC_REL    = 3'h1,
    AGFD_AM_REG_IND   = 3'h2,
    AGFD_AM_BASED1    = 3'h3,
    AGFD_AM_BASED2    = 3'h4,
    AGFD_AM_BIT       = 3'h5
  } agfd_amode_e;

  typedef struct packed {
    agfd_fmt_e   fmt;
    logic        is_long;
    logic [5:0]  opcode;
    logic [5:0]  sub_opcode;
    logic        sub_bit;
    logic [4:0]  source_register_field;
    logic [4:0]  destination_register_field;
    logic [4:0]  third_register_field;
    logic [4:0]  short_immediate;
    logic [15:0] long_immediate;
    logic [15:0] long_displacement;
    logic [21:0] jump_displacement;
    logic [8:0]  branch_displacement;
    logic [7:0]  short_displacement;
    logic [3:0]  condition_code;
    logic [2:0]  bit_number;
    logic [9:0]  ext_immediate;
    logic [11:0] register_list;
    agfd_amode_e amode;
  } agfd_fields_s;

endpackage : agfd_pkg

// ==== logic/agfd_link_if.sv ====
/*
  carries decoded fields from the format decoder to the address former.
  assumes a single clock domain; purely combinational transport.
*/
`timescale 1ns/100ps
interface agfd_link_if;
  import agfd_pkg::*;
  agfd_fields_s fields;
  modport producer (output fields);
  modport consumer (input  fields);
endinterface : agfd_link_if

// ==== logic/agfd_fmt_decode.sv ====
/*
  splits a fetched instruction word into format and fields.
  assumes the low halfword sits in bits 15:0 and the second halfword above it.
*/
`timescale 1ns/100ps
module agfd_fmt_decode
  import agfd_pkg::*;
(
  input  wire logic [31:0] instr_word,
  agfd_link_if.producer    link
);

  function automatic logic is_long_op(input logic [5:0] op);
    is_long_op = (op[5:4] == 2'b11) || (op[5:1] == 5'b11110);
  endfunction : is_long_op

  agfd_fields_s f;
  logic [5:0]   op;
  logic [15:0]  hi;

  always_comb begin
    op = instr_word[10:5];
    hi = instr_word[31:16];
    f  = '0;
    f.opcode                     = op;
    f.source_register_field      = instr_word[4:0];
    f.destination_register_field = instr_word[15:11];
    f.short_immediate            = instr_word[4:0];
    f.is_long                    = is_long_op(op);
    f.amode                      = AGFD_AM_NONE;
    f.fmt                        = AGFD_FMT_I;
    if (op[5:2] == 4'b1011) begin
      f.fmt                 = AGFD_FMT_III;
      f.opcode              = {2'h0, op[5:2]};
      f.condition_code      = instr_word[3:0];
      f.branch_displacement = {instr_word[15:11], instr_word[6:4], 1'b0};
      f.amode               = AGFD_AM_PC_REL;
    end else if (op[5:3] == 3'b010) begin
      f.fmt = AGFD_FMT_II;
    end else if (op[5:4] == 2'b01 || op[5:4] == 2'b10) begin
      f.fmt    = AGFD_FMT_IV;
      f.amode  = AGFD_AM_BASED2;
      f.opcode = {2'h0, op[5:2]};
      if (op[5:3] == 3'b011) begin
        f.short_displacement = {1'b0, instr_word[6:0]};
      end else if (op[5:3] == 3'b100) begin
        f.short_displacement = {instr_word[6:0], 1'b0};
      end else begin
        // word forms: bit 0 picks load or store
        f.short_displacement = {instr_word[6:1], 2'b00};
        f.sub_bit            = instr_word[0];
      end
    end else if (op[5:1] == 5'b11110) begin
      f.fmt               = AGFD_FMT_V;
      f.opcode            = {1'b0, op[5:1]};
      f.jump_displacement = {instr_word[5:0], hi[15:1], 1'b0};
      f.amode             = AGFD_AM_PC_REL;
    end else if (op[5:2] == 4'b1110) begin
      f.fmt               = AGFD_FMT_VII;
      f.long_displacement = hi;
      f.sub_bit           = hi[0];
      f.amode             = AGFD_AM_BASED1;
    end else if (op[5:3] == 3'b110) begin
      f.fmt            = AGFD_FMT_VI;
      f.long_immediate = hi;
    end else if (op == 6'h3e) begin
      f.fmt               = AGFD_FMT_VIII;
      f.sub_opcode        = {4'h0, instr_word[15:14]};
      f.bit_number        = instr_word[13:11];
      f.long_displacement = hi;
      f.amode             = AGFD_AM_BIT;
    end else if (op == 6'h3f) begin
      f.sub_opcode = hi[10:5];
      f.third_register_field = hi[15:11];
      f.sub_bit    = hi[0];
      if (hi[10:9] == 2'b11) begin
        f.fmt           = AGFD_FMT_XII;
        f.sub_opcode    = {2'h0, hi[10:7]};
        f.ext_immediate = {instr_word[4:0], hi[4:0]};
      end else if (hi[10:5] == 6'h10 && instr_word[15:11] == 5'h0) begin
        f.fmt = AGFD_FMT_X;
      end else if (hi[10:8] == 3'b101) begin
        f.fmt = AGFD_FMT_XI;
      end else begin
        f.fmt            = AGFD_FMT_IX;
        f.condition_code = instr_word[3:0];
      end
    end else if (op == 6'h03 && instr_word[15:11] != 5'h0) begin
      // 7-bit opcode, 4-bit displacement, bit 4 picks halfword
      f.fmt                = AGFD_FMT_IV;
      f.amode              = AGFD_AM_BASED2;
      f.short_displacement = instr_word[4] ? {3'h0, instr_word[3:0], 1'b0} : {4'h0, instr_word[3:0]};
    end else if (op[5:1] == 5'b00001 && instr_word[15:11] != 5'h0) begin
      f.fmt             = AGFD_FMT_XIII;
      f.opcode          = {1'b0, op[5:1]};
      f.short_immediate = {instr_word[0], hi[15:12]};
      f.register_list   = {instr_word[0], hi[11:1]};
    end else begin
      f.fmt = AGFD_FMT_I;
      f.amode = (op == 6'h03) ? AGFD_AM_REG_IND : AGFD_AM_NONE;
    end
    if (f.fmt == AGFD_FMT_XIII)
      f.is_long = 1'b1;
  end

  assign link.fields = f;

endmodule : agfd_fmt_decode

// ==== logic/agfd_addr_form.sv ====
/*
  forms data addresses and the next program counter from decoded fields.
  assumes register values are supplied by the register file in the same cycle.
*/
`timescale 1ns/100ps
`include "agfd_regs.svh"
module agfd_addr_form
  import agfd_pkg::*;
(
  agfd_link_if.consumer    link,
  input  wire logic [31:0] pc_cur,
  input  wire logic [31:0] src_reg_val,
  input  wire logic [31:0] ep_reg_val,
  input  wire logic        take_branch,
  output logic [31:0]      data_addr,
  output logic [31:0]      pc_next
);

  function automatic logic [31:0] sx16(input logic [15:0] v);
    sx16 = {{16{v[15]}}, v};
  endfunction : sx16

  agfd_fields_s f;
  logic [31:0]  step;

  always_comb begin
    f    = link.fields;
    step = f.is_long ? `AGFD_PC_STEP_WORD : `AGFD_PC_STEP_HALF;
    unique case (f.amode)
      AGFD_AM_BASED1: data_addr = src_reg_val + sx16(f.long_displacement);
      AGFD_AM_BASED2: data_addr = ep_reg_val + {24'h0, f.short_displacement};
      AGFD_AM_BIT:    data_addr = src_reg_val + sx16(f.long_displacement);
      default:        data_addr = 32'h0000_0000;
    endcase
    pc_next = pc_cur + step;
    // indirect jump is unconditional
    if (f.amode == AGFD_AM_REG_IND) begin
      pc_next = src_reg_val;
    end else if (take_branch) begin
      if (f.fmt == AGFD_FMT_III)
        pc_next = pc_cur + {{23{f.branch_displacement[8]}}, f.branch_displacement};
      else if (f.fmt == AGFD_FMT_V)
        pc_next = pc_cur + {{10{f.jump_displacement[21]}}, f.jump_displacement};
    end
    pc_next = pc_next & `AGFD_PROG_SPAN_MASK & 32'hffff_fffe;
  end

endmodule : agfd_addr_form

// ==== logic/agfd_top.sv ====
/*
  address generation and instruction format decode top.
  assumes the fetch unit gives a 32-bit little-endian instruction window and the
  execute unit supplies register values and branch outcome.
*/
`timescale 1ns/100ps
`include "agfd_regs.svh"
module agfd_top
  import agfd_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        instr_valid,
  input  wire logic [31:0] instr_word,
  input  wire logic [31:0] src_reg_val,
  input  wire logic [31:0] ep_reg_val,
  input  wire logic        take_branch,
  output logic [31:0]      pc_r,
  output logic [31:0]      data_addr_r,
  output logic             is_long_r,
  output logic [3:0]       fmt_r,
  output logic [4:0]       source_register_field_r,
  output logic [4:0]       destination_register_field_r,
  output logic [4:0]       short_immediate_r,
  output logic [4:0]       trap_vector_r,
  output logic [15:0]      long_immediate_r,
  output logic [3:0]       condition_code_r,
  output logic [2:0]       bit_number_r,
  output logic             code_region_ok_r
);

  agfd_link_if link ();
  logic [31:0] pc_nxt;
  logic [31:0] data_addr;
  logic [31:0] data_addr_nxt;
  logic [31:0] pc_calc;
  logic        ok_nxt;

  agfd_fmt_decode u_dec (
    .instr_word (instr_word),
    .link       (link.producer)
  );

  agfd_addr_form u_addr (
    .link        (link.consumer),
    .pc_cur      (pc_r),
    .src_reg_val (src_reg_val),
    .ep_reg_val  (ep_reg_val),
    .take_branch (take_branch),
    .data_addr   (data_addr),
    .pc_next     (pc_calc)
  );

  always_comb begin
    pc_nxt        = pc_r;
    data_addr_nxt = data_addr_r;
    ok_nxt        = code_region_ok_r;
    if (instr_valid) begin
      pc_nxt        = pc_calc;
      data_addr_nxt = data_addr;
      ok_nxt        = (pc_calc < `AGFD_CODE_LIN_LIMIT) ||
                      ((pc_calc & `AGFD_PROG_SPAN_MASK) >
                       (`AGFD_PROG_SPAN_MASK - `AGFD_IRAM_SIZE));
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pc_r                         <= `AGFD_RESET_PC;
      data_addr_r                  <= 32'h0000_0000;
      is_long_r                    <= 1'b0;
      fmt_r                        <= 4'h0;
      source_register_field_r      <= 5'h00;
      destination_register_field_r <= 5'h00;
      short_immediate_r            <= 5'h00;
      trap_vector_r                <= 5'h00;
      long_immediate_r             <= 16'h0000;
      condition_code_r             <= 4'h0;
      bit_number_r                 <= 3'h0;
      code_region_ok_r             <= 1'b1;
    end else begin
      pc_r             <= pc_nxt;
      data_addr_r      <= data_addr_nxt;
      code_region_ok_r <= ok_nxt;
      if (instr_valid) begin
        is_long_r                    <= link.fields.is_long;
        fmt_r                        <= link.fields.fmt;
        source_register_field_r      <= link.fields.source_register_field;
        destination_register_field_r <= link.fields.destination_register_field;
        short_immediate_r            <= link.fields.short_immediate;
        trap_vector_r                <= link.fields.short_immediate & `AGFD_VEC_MAX;
        long_immediate_r             <= link.fields.long_immediate;
        condition_code_r             <= link.fields.condition_code;
        bit_number_r                 <= link.fields.bit_number;
      end
    end
  end

endmodule : agfd_top

// ==== bench/agfd_top_properties.sv ====
/*
  port-level checker for the decode top.
  assumes bind onto agfd_top, one clock domain.
*/
`timescale 1ns/100ps
module agfd_top_properties (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [31:0] src_reg_val,
  input wire logic [31:0] ep_reg_val,
  input wire logic        take_branch,
  input wire logic [31:0] pc_r,
  input wire logic [31:0] data_addr_r,
  input wire logic        is_long_r,
  input wire logic [4:0]  source_register_field_r,
  input wire logic [4:0]  destination_register_field_r,
  input wire logic [4:0]  trap_vector_r,
  input wire logic [2:0]  bit_number_r
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire [5:0]  op = instr_word[10:5];
  wire [31:0] w  = instr_word;

  idle_hold_a: assert property (!instr_valid |=> $stable(pc_r) && $stable(data_addr_r))
    else $error("outputs moved while idle");
  pc_span_a: assert property (pc_r[0] == 1'b0 && pc_r[31:26] == 6'h0)
    else $error("pc outside program span");
  short_step_a: assert property (instr_valid && op < 6'h30 && op != 6'h03 && !take_branch
    |=> pc_r == (($past(pc_r) + 32'h2) & 32'h03ff_fffe)) else $error("short step wrong");
  long_step_a: assert property (instr_valid && op >= 6'h30 && op != 6'h3f && !take_branch
    |=> pc_r == (($past(pc_r) + 32'h4) & 32'h03ff_fffe)) else $error("long step wrong");
  length_flag_a: assert property (instr_valid |=> is_long_r == ($past(op) >= 6'h30))
    else $error("length flag wrong");
  jmp_target_a: assert property (instr_valid && w[15:5] == 11'h003
    |=> pc_r == ($past(src_reg_val) & 32'h03ff_fffe)) else $error("indirect target wrong");
  bcond_a: assert property (instr_valid && take_branch && w[10:7] == 4'hb
    |=> pc_r == (($past(pc_r) + {{23{$past(w[15])}}, $past(w[15:11]), $past(w[6:4]), 1'b0}) & 32'h03ff_fffe))
    else $error("branch target wrong");
  short_ld_a: assert property (instr_valid && w[10:7] == 4'h6
    |=> data_addr_r == $past(ep_reg_val) + {25'h0, $past(w[6:0])}) else $error("short load address wrong");
  fields_a: assert property (instr_valid && op < 6'h18 |=> source_register_field_r == $past(w[4:0])
    && destination_register_field_r == $past(w[15:11])) else $error("register fields wrong");
  bit_addr_a: assert property (instr_valid && op == 6'h3e
    |=> data_addr_r == $past(src_reg_val) + {{16{$past(w[31])}}, $past(w[31:16])}
    && bit_number_r == $past(w[13:11])) else $error("bit address wrong");
  trap_vec_a: assert property (instr_valid && w[15:5] == 11'h03f && w[31:16] == 16'h0100
    |=> trap_vector_r == $past(w[4:0])) else $error("trap vector wrong");
endmodule : agfd_top_properties

bind agfd_top agfd_top_properties agfd_top_properties_i (.mclk, .rst_b, .instr_valid, .instr_word,
  .src_reg_val, .ep_reg_val, .take_branch, .pc_r, .data_addr_r, .is_long_r, .source_register_field_r,
  .destination_register_field_r, .trap_vector_r, .bit_number_r);

// ==== bench/agfd_gpr_model.sv ====
/*
  register file stand-in feeding source and element pointer values.
  assumes the bench writes gpr entries directly.
*/
`timescale 1ns/100ps
module agfd_gpr_model (
  input  wire logic [4:0]  rsel,
  output logic      [31:0] src_val,
  output logic      [31:0] ep_val
);
  logic [31:0] gpr [32];
  initial for (int i = 0; i < 32; i++) gpr[i] = {8'h5a, 19'h0, i[4:0]};
  assign src_val = (rsel == 5'h0) ? 32'h0 : gpr[rsel];
  assign ep_val  = gpr[30];
endmodule : agfd_gpr_model

// ==== bench/agfd_top_tb.sv ====
/*
  self-checking bench for the decode top.
  assumes agfd_top, its checker bind and the register model.
*/
`timescale 1ns/100ps
module agfd_top_tb;
  import agfd_pkg::*;
  logic        mclk = 1'b0, rst_b = 1'b0, instr_valid = 1'b0, take_branch = 1'b0;
  logic [31:0] instr_word = 32'h0, epc = 32'h0;
  logic [31:0] src_reg_val, ep_reg_val, pc_r, data_addr_r;
  logic        is_long_r, code_region_ok_r;
  logic [3:0]  fmt_r, condition_code_r;
  logic [4:0]  source_register_field_r, destination_register_field_r, short_immediate_r, trap_vector_r;
  logic [15:0] long_immediate_r;
  logic [2:0]  bit_number_r;
  int          num_errors = 0, comparisons = 0, cyc = 0;

  agfd_gpr_model agfd_gpr_model_i (.rsel(instr_word[4:0]), .src_val(src_reg_val), .ep_val(ep_reg_val));
  agfd_top agfd_top_i (.mclk, .rst_b, .instr_valid, .instr_word, .src_reg_val, .ep_reg_val, .take_branch,
    .pc_r, .data_addr_r, .is_long_r, .fmt_r, .source_register_field_r, .destination_register_field_r,
    .short_immediate_r, .trap_vector_r, .long_immediate_r, .condition_code_r, .bit_number_r, .code_region_ok_r);

  always #12.5 mclk = ~mclk;

  task automatic summarize();
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one instruction retired, then idle
  task automatic run(input logic [31:0] w, input logic br, input logic [31:0] step);
    @(negedge mclk);
    instr_valid = 1'b1;
    instr_word  = w;
    take_branch = br;
    @(negedge mclk);
    instr_valid = 1'b0;
    take_branch = 1'b0;
    epc = (epc + step) & 32'h03ff_fffe;
  endtask : run

  task automatic t_short();
    run({16'h0, 5'd2, 6'h0e, 5'd1}, 1'b0, 32'h2);
    check(pc_r, epc);
    check(fmt_r, AGFD_FMT_I);
    check({source_register_field_r, destination_register_field_r}, {5'd1, 5'd2});
    check(is_long_r, 1'b0);
    run({16'h0, 5'd3, 6'h10, 5'h15}, 1'b0, 32'h2);
    check(short_immediate_r, 5'h15);
    check(fmt_r, AGFD_FMT_II);
    repeat (3) @(negedge mclk);
    check(pc_r, epc);
  endtask : t_short

  task automatic t_branch();
    run({16'h0, 5'h1f, 4'hb, 3'b100, 4'h2}, 1'b1, -32'sd8);
    check(pc_r, epc);
    check(fmt_r, AGFD_FMT_III);
    run({16'h0, 5'h1f, 4'hb, 3'b100, 4'h2}, 1'b0, 32'h2);
    check(pc_r, epc);
    run({16'h0100, 5'd0, 5'h1e, 6'h00}, 1'b1, 32'h100);
    check(pc_r, epc);
    check(fmt_r, AGFD_FMT_V);
    check(is_long_r, 1'b1);
    run({16'hfe00, 5'd31, 5'h1e, 6'h3f}, 1'b1, -32'sd512);
    check(pc_r, epc);
  endtask : t_branch

  task automatic t_jump();
    logic [31:0] tgt [5] = '{32'h00ff_ffff, 32'h0100_0000, 32'hffff_f001, 32'h03ff_0fff, 32'h03ff_1000};
    logic        ok  [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 5; i++) begin
      agfd_gpr_model_i.gpr[5] = tgt[i];
      run({16'h0, 5'd0, 6'h03, 5'd5}, 1'b0, 32'h0);
      epc = tgt[i] & 32'h03ff_fffe;
      check(pc_r, epc);
      check(code_region_ok_r, ok[i]);
    end
  endtask : t_jump

  task automatic t_mem();
    agfd_gpr_model_i.gpr[5]  = 32'h00ff_ffff;
    agfd_gpr_model_i.gpr[6]  = 32'h0100_0000;
    agfd_gpr_model_i.gpr[30] = 32'h0000_1000;
    run({16'h0010, 5'd2, 6'h38, 5'd5}, 1'b0, 32'h4);
    check(data_addr_r, 32'h0100_000f);
    check(fmt_r, AGFD_FMT_VII);
    check(pc_r, epc);
    run({16'h8001, 5'd2, 6'h30, 5'd5}, 1'b0, 32'h4);
    check(long_immediate_r, 16'h8001);
    check(fmt_r, AGFD_FMT_VI);
    run({16'hfff0, 2'b00, 3'd5, 6'h3e, 5'd6}, 1'b0, 32'h4);
    check(data_addr_r, 32'h00ff_fff0);
    check(bit_number_r, 3'd5);
    check(fmt_r, AGFD_FMT_VIII);
    run({16'h0, 5'd3, 4'h6, 7'h7f}, 1'b0, 32'h2);
    check(data_addr_r, 32'h0000_107f);
    check(fmt_r, AGFD_FMT_IV);
    check(pc_r, epc);
    run({16'h0, 5'd3, 7'h07, 4'h5}, 1'b0, 32'h2);
    check(data_addr_r, 32'h0000_100a);
    check(fmt_r, AGFD_FMT_IV);
    check(pc_r, epc);
  endtask : t_mem

  task automatic t_trap();
    logic [4:0] vec [2] = '{5'h00, 5'h1f};
    for (int i = 0; i < 2; i++) begin
      run({16'h0100, 5'd0, 6'h3f, vec[i]}, 1'b0, 32'h4);
      check(trap_vector_r, vec[i]);
      check(is_long_r, 1'b1);
    end
    run({16'h0000, 5'd4, 6'h3f, 5'h0b}, 1'b0, 32'h4);
    check(condition_code_r, 4'hb);
    check(fmt_r, AGFD_FMT_IX);
    run({16'h0200, 5'd0, 6'h3f, 5'd0}, 1'b0, 32'h4);
    check(fmt_r, AGFD_FMT_X);
    run({16'h0500, 5'd1, 6'h3f, 5'd2}, 1'b0, 32'h4);
    check(fmt_r, AGFD_FMT_XI);
    run({16'h0600, 5'd1, 6'h3f, 5'd2}, 1'b0, 32'h4);
    check(fmt_r, AGFD_FMT_XII);
    check(pc_r, epc);
  endtask : t_trap

  initial begin
    repeat (8) @(posedge mclk);
    check(pc_r, 32'h0);
    check(data_addr_r, 32'h0);
    check(code_region_ok_r, 1'b1);
    @(negedge mclk);
    rst_b = 1'b1;
    t_short();
    t_branch();
    t_jump();
    t_mem();
    t_trap();
    summarize();
  end
endmodule : agfd_top_tb
